// >>> hw/stack_pkg.sv
/*
 Constants for the software stack pointer and limit checker.
 Assumes a 16-bit data space with word-aligned stack accesses.
*/
package stack_pkg;
    localparam int DATA_W = 16;
    localparam int PC_W = 23;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] SP_RESET = 16'h0800;
    localparam logic [15:0] ALIGN_MASK = 16'hFFFE;
    localparam int PC_HI_LSB = 16;
    localparam int PC_HI_MSB = 22;
    localparam int SR_LOW_W = 8;
    typedef enum logic [1:0] {OP_NONE, OP_PUSH, OP_POP, OP_EA} stack_op_e;
endpackage

// >>> hw/stack_pointer_limit_check.sv
/*
 Stack pointer, stack limit register and stack error trap generation.
 Assumes the core issues at most one stack request per cycle, on the core clock.
*/
`timescale 1ns/1ps
module stack_pointer_limit_check (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic call_push_in,
    input wire logic exc_push_in,
    input wire logic [22:0] pc_in,
    input wire logic [7:0] status_low_byte_in,
    input wire logic [15:0] push_data_in,
    input wire logic sp_write_in,
    input wire logic [15:0] sp_wdata_in,
    input wire logic limit_write_in,
    input wire logic [15:0] limit_wdata_in,
    input wire logic ea_valid_in,
    input wire logic [15:0] ea_in,
    output logic mem_valid_out,
    output logic mem_write_out,
    output logic [15:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    output logic [15:0] stack_pointer_register_out,
    output logic [15:0] stack_limit_register_out,
    output logic stack_trap_out
);
    logic [15:0] sp_q, sp_d;
    logic [15:0] lim_q, lim_d;
    logic mv_q, mv_d, mw_q, mw_d, trap_q, trap_d;
    logic [15:0] ma_q, ma_d, md_q, md_d;
    logic any_push;
    logic any_access;
    logic [15:0] pop_addr;

    // Address beyond the limit or under the floor
    function automatic logic out_of_bounds(input logic [15:0] a, input logic [15:0] lim);
        out_of_bounds = (a > lim) || (a < stack_pkg::STACK_FLOOR);
    endfunction

    assign any_push = push_in | call_push_in | exc_push_in;
    assign any_access = any_push | pop_in | ea_valid_in;
    assign pop_addr = sp_q - stack_pkg::WORD_STEP;

    always_comb begin
        sp_d = sp_q;
        lim_d = lim_q;
        mv_d = 1'b0;
        mw_d = 1'b0;
        ma_d = ma_q;
        md_d = md_q;
        trap_d = 1'b0;
        if (limit_write_in) begin
            lim_d = limit_wdata_in & stack_pkg::ALIGN_MASK;
        end
        if (sp_write_in) begin
            sp_d = sp_wdata_in & stack_pkg::ALIGN_MASK;
        end else if (any_push) begin
            mv_d = 1'b1;
            mw_d = 1'b1;
            ma_d = sp_q;
            if (call_push_in) begin
                md_d = {8'h00, 1'b0, pc_in[stack_pkg::PC_HI_MSB:stack_pkg::PC_HI_LSB]};
            end else if (exc_push_in) begin
                md_d = {status_low_byte_in, 1'b0, pc_in[stack_pkg::PC_HI_MSB:stack_pkg::PC_HI_LSB]};
            end else begin
                md_d = push_data_in;
            end
            sp_d = sp_q + stack_pkg::WORD_STEP;
            trap_d = out_of_bounds(sp_q, lim_q);
        end else if (pop_in) begin
            mv_d = 1'b1;
            sp_d = pop_addr;
            ma_d = pop_addr;
            trap_d = out_of_bounds(pop_addr, lim_q);
        end else if (ea_valid_in) begin
            trap_d = out_of_bounds(ea_in, lim_q);
        end
    end

    // Pointer and bus regs reset; limit is deliberately not reset
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sp_q <= stack_pkg::SP_RESET;
            mv_q <= 1'b0;
            mw_q <= 1'b0;
            ma_q <= 16'h0000;
            md_q <= 16'h0000;
            trap_q <= 1'b0;
        end else begin
            sp_q <= sp_d;
            mv_q <= mv_d;
            mw_q <= mw_d;
            ma_q <= ma_d;
            md_q <= md_d;
            trap_q <= trap_d;
        end
    end

    always_ff @(posedge core_clk_in) begin
        lim_q <= lim_d;
    end

    assign mem_valid_out = mv_q;
    assign mem_write_out = mw_q;
    assign mem_addr_out = ma_q;
    assign mem_wdata_out = md_q;
    assign stack_pointer_register_out = sp_q;
    assign stack_limit_register_out = lim_q;
    assign stack_trap_out = trap_q;

    // Request classes as the core presents them on one rising edge
    sequence s_any_push;
        any_push && !sp_write_in;
    endsequence

    sequence s_data_push;
        push_in && !call_push_in && !exc_push_in && !sp_write_in;
    endsequence

    sequence s_call_push;
        call_push_in && !sp_write_in;
    endsequence

    sequence s_exc_push;
        exc_push_in && !call_push_in && !sp_write_in;
    endsequence

    sequence s_pop;
        pop_in && !any_push && !sp_write_in;
    endsequence

    sequence s_ea_only;
        ea_valid_in && !any_push && !pop_in && !sp_write_in;
    endsequence

    sequence s_sp_idle;
        !any_push && !pop_in && !sp_write_in;
    endsequence

    sequence s_quiet;
        !any_access && !sp_write_in;
    endsequence

    sequence s_push_at(logic [15:0] p);
        push_in && !sp_write_in && !call_push_in && !exc_push_in && sp_q == p;
    endsequence

    a_sp_aligned: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        stack_pointer_register_out[0] == 1'b0)
        else $error("stack pointer not word aligned");
    a_sp_load: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        sp_write_in
        |=> stack_pointer_register_out == ($past(sp_wdata_in) & stack_pkg::ALIGN_MASK))
        else $error("pointer load not word aligned");
    a_sp_holds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_sp_idle
        |=> $stable(stack_pointer_register_out))
        else $error("pointer moved without a stack access");
    a_push_increments: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_any_push
        |=> (sp_q == $past(sp_q) + stack_pkg::WORD_STEP && mem_addr_out == $past(sp_q) && mem_write_out))
        else $error("push did not write at pointer then increment");
    a_pop_decrements: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_pop
        |=> (sp_q == $past(sp_q) - stack_pkg::WORD_STEP && mem_addr_out == sp_q && !mem_write_out))
        else $error("pop did not decrement then read");
    a_push_data: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_data_push
        |=> mem_wdata_out == $past(push_data_in))
        else $error("pushed word differs from push data");
    a_call_top_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_call_push
        |=> (mem_wdata_out[15:7] == 9'h000))
        else $error("call push upper byte not zero extended");
    a_exc_join_status: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_exc_push
        |=> (mem_wdata_out[15:8] == $past(status_low_byte_in)))
        else $error("exception push lacks status low byte");
    a_limit_load: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        limit_write_in
        |=> stack_limit_register_out == ($past(limit_wdata_in) & stack_pkg::ALIGN_MASK))
        else $error("limit load lost");
    a_limit_aligned: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        limit_write_in
        |=> (stack_limit_register_out[0] == 1'b0))
        else $error("limit bit 0 not forced to zero");

    // Bound checks; an unwritten limit makes the antecedents that compare against lim_q unknown, so those stay quiet; the floor checks do not use it
    a_ea_over_limit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_ea_only ##0 (ea_in > lim_q))
        |=> stack_trap_out)
        else $error("address above limit not trapped");
    a_ea_in_bounds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_ea_only ##0 (ea_in <= lim_q && ea_in >= stack_pkg::STACK_FLOOR))
        |=> !stack_trap_out)
        else $error("address inside bounds trapped");
    a_push_at_limit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_push_at(lim_q) ##0 (lim_q >= stack_pkg::STACK_FLOOR && !limit_write_in))
        |=> (!stack_trap_out ##0 s_any_push)
        |=> stack_trap_out)
        else $error("limit push trap timing wrong");
    a_push_in_bounds: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_any_push ##0 (sp_q <= lim_q && sp_q >= stack_pkg::STACK_FLOOR))
        |=> !stack_trap_out)
        else $error("push inside bounds trapped");
    a_floor_trap: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_ea_only ##0 (ea_in < stack_pkg::STACK_FLOOR))
        |=> stack_trap_out)
        else $error("underflow trap missing");
    a_pop_underflow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_pop ##0 (pop_addr < stack_pkg::STACK_FLOOR))
        |=> stack_trap_out)
        else $error("pop below floor not trapped");
    a_push_underflow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_any_push ##0 (sp_q < stack_pkg::STACK_FLOOR))
        |=> stack_trap_out)
        else $error("push below floor not trapped");

    // Pulses last one cycle and only follow an access
    a_trap_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        stack_trap_out
        |-> $past(any_access))
        else $error("trap without a stack access");
    a_mem_pulse: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        s_quiet
        |=> (!mem_valid_out && !stack_trap_out))
        else $error("access pulse outlived its request");
endmodule

// >>> verif/core_trap_model.sv
/*
 Trap side of the core: counts cycles with a stack error trap request.
 Assumes one trap cycle per faulting access.
*/
`timescale 1ns/1ps
module core_trap_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic stack_trap_in,
    output logic [7:0] trap_count_out
);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            trap_count_out <= 8'h00;
        end else if (stack_trap_in) begin
            trap_count_out <= trap_count_out + 8'h01;
        end
    end
endmodule

// >>> verif/tb_top.sv
/*
 Self-checking bench for the stack pointer limit checker.
 Assumes outputs settle one cycle after a request edge.
*/
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst_n = 0, push = 0, pop = 0, cp = 0, ep = 0, lw = 0, eav = 0, spw = 0;
    logic [22:0] pc = 0;
    logic [7:0] sr = 0, tc;
    logic [15:0] pd = 0, ld = 0, ea = 0, s = 16'h0800, spd = 0, lim, ma, md, sp, sl;
    logic mv, mw, tr;
    logic [33:0] q[$];
    int seed, failures = 0, compares = 0;
    stack_pointer_limit_check dut (.core_clk_in(clk), .rst_n_in(rst_n), .push_in(push), .pop_in(pop),
        .call_push_in(cp), .exc_push_in(ep), .pc_in(pc), .status_low_byte_in(sr), .push_data_in(pd),
        .sp_write_in(spw), .sp_wdata_in(spd), .limit_write_in(lw), .limit_wdata_in(ld),
        .ea_valid_in(eav), .ea_in(ea), .mem_valid_out(mv), .mem_write_out(mw), .mem_addr_out(ma),
        .mem_wdata_out(md), .stack_pointer_register_out(sp), .stack_limit_register_out(sl),
        .stack_trap_out(tr));
    core_trap_model model (.clk_in(clk), .rst_n_in(rst_n), .stack_trap_in(tr), .trap_count_out(tc));
    initial forever #2.5 clk = ~clk;
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic req(input logic [3:0] k);
        logic [15:0] w;
        logic [15:0] a;
        w = 16'($random(seed));
        pc = 23'($random(seed));
        sr = 8'($random(seed));
        {cp, ep, push, pop} = k;
        pd = w;
        if (k[3]) w = {8'h00, 1'b0, pc[22:16]};
        if (k[2]) w = {sr, 1'b0, pc[22:16]};
        if (k != 4'h0) begin
            if (k == 4'h1) s = s - 16'h0002;
            a = s;
            if (k != 4'h1) s = s + 16'h0002;
            q.push_back({k != 4'h1, a, k != 4'h1 ? w : 16'h0000, a > lim || a < 16'h0800});
        end
        @(negedge clk);
    endtask
    always @(negedge clk) begin
        if (rst_n && mv === 1'b1) begin
            check({mw, ma, mw ? md : 16'h0000, tr}, q.size() > 0 ? q.pop_front() : 34'h0);
        end
    end
    initial begin
        seed = 32'h0f490495;
        repeat (4) @(negedge clk);
        rst_n = 1;
        check({18'h0, sp}, {18'h0, 16'h0800});
        lw = 1;
        ld = 16'h0805;
        @(negedge clk);
        lw = 0;
        lim = 16'h0804;
        @(negedge clk);
        check({18'h0, sl}, {18'h0, lim});
        repeat (4) req(4'h2);
        req(4'h8);
        req(4'h4);
        repeat (7) req(4'h1);
        req(4'h0);
        check({18'h0, sp}, {18'h0, 16'h07FE});
        eav = 1;
        ea = 16'h0806;
        @(negedge clk);
        eav = 0;
        @(negedge clk);
        check({26'h0, tc}, {26'h0, 8'h08});
        check({18'h0, 16'(q.size())}, 34'h0);
        $display("test stack walk done");
        spw = 1;
        spd = 16'h07FD;
        @(negedge clk);
        spw = 0;
        s = 16'h07FC;
        check({18'h0, sp}, {18'h0, s});
        req(4'h2);
        req(4'h0);
        eav = 1;
        ea = 16'h07F0;
        @(negedge clk);
        ea = 16'h0802;
        @(negedge clk);
        eav = 0;
        @(negedge clk);
        check({26'h0, tc}, {26'h0, 8'h0A});
        check({18'h0, 16'(q.size())}, 34'h0);
        check({18'h0, sp}, {18'h0, 16'h07FE});
        $display("test pointer load done");
        conclude();
    end
    initial begin
        #2000;
        failures++;
        conclude();
    end
endmodule
